// File: rtl/csud_pkg.sv
// Constants, types and the register map of the carry subtract, multiply and divide unit.
// Assumes a 32-bit APB master with byte addresses in an 8-bit window.
package csud_pkg;

  // Byte offsets of the control registers.
  localparam logic [7:0] CSUD_OFF_CMD   = 8'h00;
  localparam logic [7:0] CSUD_OFF_FLAGS = 8'h04;
  localparam logic [7:0] CSUD_OFF_ISTAT = 8'h08;
  localparam logic [7:0] CSUD_OFF_IMASK = 8'h0C;
  // Operand words sit at 0x40 + 4 * index, sixteen of them.
  localparam logic [1:0] CSUD_WORD_PAGE = 2'h1;
  localparam int         CSUD_WORDS     = 16;

  // Command register fields.
  localparam int CSUD_CMD_OP_LSB = 0;
  localparam int CSUD_CMD_EN_BIT = 2;
  localparam int CSUD_CMD_A_LSB  = 4;
  localparam int CSUD_CMD_B_LSB  = 8;
  localparam int CSUD_CMD_C_LSB  = 12;

  // Flag register fields.
  localparam int CSUD_FLG_CARRY = 0;
  localparam int CSUD_FLG_ERROR = 1;
  localparam int CSUD_FLG_OVF   = 2;
  localparam int CSUD_FLG_MUL   = 3;
  localparam int CSUD_FLG_DIV   = 4;

  // Interrupt status and mask fields.
  localparam int CSUD_IRQ_OVF  = 0;
  localparam int CSUD_IRQ_DERR = 1;
  localparam int CSUD_IRQ_DONE = 2;
  localparam int CSUD_IRQ_BITS = 3;

  // Values after reset.
  localparam logic [15:0] CSUD_CMD_RST   = 16'h0000;
  localparam logic [15:0] CSUD_WORD_RST  = 16'h0000;
  localparam logic [2:0]  CSUD_IMASK_RST = 3'h0;

  typedef enum logic [1:0] {
    CSUD_OP_NONE = 2'b00,
    CSUD_OP_SUB  = 2'b01,
    CSUD_OP_MUL  = 2'b10,
    CSUD_OP_DIV  = 2'b11
  } csud_op_t;

  typedef enum logic [0:0] {
    CSUD_IDLE = 1'b0,
    CSUD_EXEC = 1'b1
  } csud_state_t;

endpackage

// File: rtl/csud_rst_sync.sv
// Reset release synchroniser for the arithmetic unit.
// Assumes an asynchronous active-low reset that may be released at any time.
`timescale 1ns/10ps
`default_nettype none
module csud_rst_sync (
  input  wire logic clk,        // System clock.
  input  wire logic reset_n,    // Raw asynchronous reset, active low.
  output logic      rst_n       // Reset released on the clock, active low.
);
  logic stage_n;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      stage_n <= 1'b0;
      rst_n   <= 1'b0;
    end
    else
    begin
      stage_n <= 1'b1;
      rst_n   <= stage_n;
    end
  end
endmodule
`default_nettype wire

// File: rtl/csud_unit.sv
// Carry subtract, unsigned multiply and unsigned divide unit with an APB register port.
// Assumes one clock, an APB master and a sequencer issuing one command at a time.
`timescale 1ns/10ps
`default_nettype none
module csud_unit
  import csud_pkg::*;
(
  input  wire logic        clk,           // System clock, 20 MHz.
  input  wire logic        reset_n,       // Asynchronous reset, active low.
  input  wire logic        psel,          // APB select.
  input  wire logic        penable,       // APB enable.
  input  wire logic        pwrite,        // APB direction, high for write.
  input  wire logic [7:0]  paddr,         // APB byte address.
  input  wire logic [31:0] pwdata,        // APB write data.
  output logic      [31:0] prdata,        // APB read data.
  output logic             pready,        // APB ready.
  output logic             pslverr,       // APB error on unmapped address.
  output logic             sub_overflow,  // Overflow/underflow of last subtraction.
  output logic             mul_exec,      // Last multiply executed.
  output logic             div_exec,      // Last divide executed.
  output logic             carry_flag,    // Borrow flag of the subtraction.
  output logic             error_flag,    // Sticky division error flag.
  output logic             irq            // Level interrupt.
);

  logic              rst_n;
  logic       [15:0] cmd;
  logic              go;
  csud_state_t       state;
  csud_state_t       next_state;
  logic       [2:0]  istat;
  logic       [2:0]  imask;
  logic       [2:0]  next_imask;
  logic       [15:0] rf [CSUD_WORDS];
  logic       [255:0] rf_flat;

  csud_rst_sync u_rst_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .rst_n   (rst_n)
  );

  // APB decode.
  wire        setup     = psel & ~penable;
  wire        acc_done  = psel & penable & pready;
  wire        bus_wr    = acc_done & pwrite;
  wire        bus_rd    = acc_done & ~pwrite;
  wire        hit_cmd   = (paddr == CSUD_OFF_CMD);
  wire        hit_flags = (paddr == CSUD_OFF_FLAGS);
  wire        hit_istat = (paddr == CSUD_OFF_ISTAT);
  wire        hit_imask = (paddr == CSUD_OFF_IMASK);
  wire        hit_word  = (paddr[7:6] == CSUD_WORD_PAGE) & (paddr[1:0] == 2'h0);
  wire [3:0]  bus_idx   = paddr[5:2];
  wire        mapped    = hit_cmd | hit_flags | hit_istat | hit_imask | hit_word;

  // Command fields.
  wire [1:0]  cmd_op = cmd[CSUD_CMD_OP_LSB +: 2];
  wire        cmd_en = cmd[CSUD_CMD_EN_BIT];
  wire [3:0]  ia     = cmd[CSUD_CMD_A_LSB +: 4];
  wire [3:0]  ib     = cmd[CSUD_CMD_B_LSB +: 4];
  wire [3:0]  ic     = cmd[CSUD_CMD_C_LSB +: 4];
  wire [3:0]  ia1    = ia + 4'h1;
  wire [3:0]  ib1    = ib + 4'h1;
  wire [3:0]  ic1    = ic + 4'h1;
  wire        exec   = (state == CSUD_EXEC);
  wire        is_sub = exec & (cmd_op == CSUD_OP_SUB);
  wire        is_mul = exec & (cmd_op == CSUD_OP_MUL);
  wire        is_div = exec & (cmd_op == CSUD_OP_DIV);

  wire [31:0] sub_a = {rf[ia1], rf[ia]};
  wire [31:0] sub_b = {rf[ib1], rf[ib]};
  wire [32:0] udiff = {1'b0, sub_a} - {1'b0, sub_b} - {32'h0000_0000, carry_flag};
  wire [32:0] sdiff = {sub_a[31], sub_a} - {sub_b[31], sub_b} - {32'h0000_0000, carry_flag};
  // Borrow out of the top bit.
  wire        borrow  = udiff[32];
  wire        sub_ovf = sdiff[32] ^ sdiff[31];

  wire [31:0] prod     = {16'h0000, rf[ia]} * {16'h0000, rf[ib]};
  wire        div_zero = (rf[ib] == 16'h0000);
  wire [15:0] quot     = div_zero ? 16'h0000 : rf[ia] / rf[ib];
  wire [15:0] remd     = div_zero ? 16'h0000 : rf[ia] % rf[ib];

  wire        ex_sub    = is_sub & cmd_en;
  wire        ex_mul    = is_mul & cmd_en;
  wire        ex_div    = is_div & cmd_en & ~div_zero;
  wire        ex_derr   = is_div & cmd_en & div_zero;
  wire        res_we    = ex_sub | ex_mul | ex_div;
  wire [15:0] res_lo    = ex_sub ? udiff[15:0]  : ex_mul ? prod[15:0]  : quot;
  wire [15:0] res_hi    = ex_sub ? udiff[31:16] : ex_mul ? prod[31:16] : remd;

  // Operand words; a result write and a bus write never meet on one edge.
  genvar k;
  generate
    for (k = 0; k < CSUD_WORDS; k = k + 1)
    begin : g_word
      wire hit_lo = res_we & (ic == 4'(k));
      wire hit_hi = res_we & (ic1 == 4'(k));
      wire hit_bw = bus_wr & hit_word & (bus_idx == 4'(k));
      wire [15:0] wd = hit_lo ? res_lo : hit_hi ? res_hi : pwdata[15:0];
      csud_word u_word (
        .clk   (clk),
        .rst_n (rst_n),
        .we    (hit_lo | hit_hi | hit_bw),
        .wdata (wd),
        .q     (rf[k])
      );
      assign rf_flat[k*16 +: 16] = rf[k];
    end
  endgenerate

  // Read data selection.
  wire [31:0] flags_rd = {27'h0, div_exec, mul_exec, sub_overflow, error_flag, carry_flag};
  wire [31:0] next_prdata = hit_cmd   ? {16'h0000, cmd} :
                            hit_flags ? flags_rd :
                            hit_istat ? {29'h0, istat} :
                            hit_imask ? {29'h0, imask} :
                            hit_word  ? {16'h0000, rf[bus_idx]} : 32'h0000_0000;

  // Interrupt events; a read clears only the bits it returned, new events win.
  wire [2:0] events;
  assign events[CSUD_IRQ_OVF]  = ex_sub & sub_ovf;
  assign events[CSUD_IRQ_DERR] = ex_derr;
  assign events[CSUD_IRQ_DONE] = exec;
  wire [2:0] istat_clr  = (bus_rd & hit_istat) ? prdata[2:0] : 3'h0;
  wire [2:0] next_istat = (istat & ~istat_clr) | events;

  // Error flag is cleared by writing one to its bit.
  wire err_clr    = bus_wr & hit_flags & pwdata[CSUD_FLG_ERROR];
  // Set wins over a simultaneous clear.
  wire next_error = ex_derr | (error_flag & ~err_clr);

  // A command write starts one execute cycle right after its access edge.
  assign go         = bus_wr & hit_cmd;
  assign next_imask = (bus_wr & hit_imask) ? pwdata[2:0] : imask;

  always_comb
  begin
    case (state)
      CSUD_IDLE: next_state = go ? CSUD_EXEC : CSUD_IDLE;
      CSUD_EXEC: next_state = go ? CSUD_EXEC : CSUD_IDLE;
      default:   next_state = CSUD_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= setup ? next_prdata : prdata;
      pslverr <= setup & ~mapped;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cmd   <= CSUD_CMD_RST;
      state <= CSUD_IDLE;
      imask <= CSUD_IMASK_RST;
    end
    else
    begin
      cmd   <= (bus_wr & hit_cmd) ? pwdata[15:0] : cmd;
      state <= next_state;
      imask <= next_imask;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      carry_flag <= 1'b0;
      error_flag <= 1'b0;
      istat      <= 3'h0;
      irq        <= 1'b0;
    end
    else
    begin
      if (ex_sub)
        carry_flag <= borrow;
      else if (bus_wr & hit_flags)
        carry_flag <= pwdata[CSUD_FLG_CARRY];
      error_flag <= next_error;
      istat      <= next_istat;
      irq        <= |(next_istat & next_imask);
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sub_overflow <= 1'b0;
      mul_exec     <= 1'b0;
      div_exec     <= 1'b0;
    end
    else
    begin
      // Overflow output from the last subtraction.
      if (is_sub)
        sub_overflow <= cmd_en & sub_ovf;
      if (is_mul)
        mul_exec <= cmd_en;
      // Divide output on only for a nonzero divisor.
      if (is_div)
        div_exec <= cmd_en & ~div_zero;
    end
  end

  // Subtraction with enable off keeps every word and the carry.
  sub_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    (is_sub && !cmd_en) |=> ($stable(carry_flag) && $stable(rf_flat) && !sub_overflow))
    else $error("Disabled subtraction changed state.");

  // Enabled subtraction writes the pair.
  sub_result_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_sub |=> ({rf[$past(ic1)], rf[$past(ic)]} ==
                $past(sub_a) - $past(sub_b) - {31'h0, $past(carry_flag)}))
    else $error("Subtraction result wrong.");

  // Carry follows unsigned borrow.
  borrow_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_sub |=> (carry_flag == ($past({1'b0, sub_a}) <
                               ($past({1'b0, sub_b}) + {32'h0, $past(carry_flag)}))))
    else $error("Carry flag does not match borrow.");

  // Overflow output tracks the signed range.
  sub_range_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_sub |=> (sub_overflow == ($past($signed(sdiff)) > 33'sh0_7FFF_FFFF ||
                                 $past($signed(sdiff)) < -33'sh0_8000_0000)))
    else $error("Overflow output wrong.");

  // Multiply product and output.
  mul_product_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_mul |=> (mul_exec && {rf[$past(ic1)], rf[$past(ic)]} ==
                {16'h0, $past(rf[ia])} * {16'h0, $past(rf[ib])}))
    else $error("Multiply product wrong.");

  // Disabled multiply or divide keeps its output off and the words still.
  md_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    ((is_mul || is_div) && !cmd_en) |=> (!mul_exec || !$past(is_mul)) &&
                                        (!div_exec || !$past(is_div)) && $stable(rf_flat))
    else $error("Disabled multiply or divide acted.");

  // Nonzero divide reconstructs the dividend.
  div_ok_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_div |=> (div_exec && rf[$past(ic1)] < $past(rf[ib]) &&
                {16'h0, rf[$past(ic)]} * {16'h0, $past(rf[ib])} + {16'h0, rf[$past(ic1)]}
                == {16'h0, $past(rf[ia])}))
    else $error("Divide result wrong.");

  // Zero divisor flags an error and writes nothing.
  div_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_derr |=> (error_flag && !div_exec && $stable(rf_flat)))
    else $error("Zero divide handled wrongly.");

  // Error flag stays until a clearing write.
  err_sticky_a: assert property (@(posedge clk) disable iff (!rst_n)
    (error_flag && !err_clr) |=> error_flag)
    else $error("Error flag dropped by itself.");

  // Interrupt follows unmasked status within one cycle.
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 (irq == |(istat & imask)))
    else $error("Interrupt level wrong.");

  // Zero wait APB answer.
  apb_ready_a: assert property (@(posedge clk) disable iff (!rst_n)
    setup |=> pready ##1 !pready)
    else $error("APB ready timing wrong.");

  // Carry moves only on a subtraction or a flag write.
  carry_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(ex_sub || (bus_wr && hit_flags)) |=> $stable(carry_flag))
    else $error("Carry flag changed without cause.");

  // Words move only on a result write or a bus word write.
  word_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    !(res_we || (bus_wr && hit_word)) |=> $stable(rf_flat))
    else $error("Operand word changed without cause.");

  // Error flag rises only after a zero divide.
  err_rise_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(error_flag) |-> $past(ex_derr))
    else $error("Error flag set without a zero divide.");

  // Unsigned quotient never exceeds the dividend.
  quot_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    ex_div |=> (rf[$past(ic)] <= $past(rf[ia])))
    else $error("Quotient above dividend.");

  // Overflow output belongs to subtractions only.
  ovf_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
    (exec && !is_sub) |=> $stable(sub_overflow))
    else $error("Overflow output moved on another operation.");

  // A command executes for exactly one cycle.
  exec_once_a: assert property (@(posedge clk) disable iff (!rst_n)
    exec |=> !exec)
    else $error("Execute cycle repeated.");

  // Error response marks exactly the unmapped accesses.
  slverr_map_a: assert property (@(posedge clk) disable iff (!rst_n)
    acc_done |-> (pslverr == !mapped))
    else $error("APB error response wrong.");

  // Status bits stay set until a read returns them.
  istat_keep_a: assert property (@(posedge clk) disable iff (!rst_n)
    (istat_clr == 3'h0) |=> ((istat & $past(istat)) == $past(istat)))
    else $error("Interrupt status bit lost.");

endmodule
`default_nettype wire

// File: rtl/csud_word.sv
// One 16-bit operand word of the unit's register file.
// Assumes the caller merges bus and result writes into one strobe.
`timescale 1ns/10ps
`default_nettype none
module csud_word
  import csud_pkg::*;
(
  input  wire logic        clk,     // System clock.
  input  wire logic        rst_n,   // Synchronised reset, active low.
  input  wire logic        we,      // Write strobe.
  input  wire logic [15:0] wdata,   // Write data.
  output logic      [15:0] q        // Stored word.
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= CSUD_WORD_RST;
    else if (we)
      q <= wdata;
  end
endmodule
`default_nettype wire

// File: tb/csud_seq.sv
// Behavioural instruction sequencer that reaches the unit over APB.
// Assumes a zero-or-more wait state slave; a wait of 16 cycles or more marks it hung.
`timescale 1ns/10ps
`default_nettype none
module csud_seq (
  input  wire logic        clk,      // System clock.
  output logic             psel,     // APB select.
  output logic             penable,  // APB enable.
  output logic             pwrite,   // APB direction.
  output logic      [7:0]  paddr,    // APB byte address.
  output logic      [31:0] pwdata,   // APB write data.
  input  wire logic [31:0] prdata,   // APB read data.
  input  wire logic        pready,   // APB ready.
  input  wire logic        pslverr,  // APB error.
  output logic             hung      // A transfer never completed.
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    hung = 1'b0;
  end

  // Request is held until pready is seen high or 16 wait cycles pass; on release the address and write data show inverted values.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 16)
      begin
        @(posedge clk);
        n++;
      end
      hung = hung | (n >= 16);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      paddr <= ~a;
      pwdata <= ~d;
    end
  endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Self-checking bench of the subtract, multiply and divide unit.
// Assumes the command, flag, interrupt and word map of the package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin errors++; \
  $display("wrong value at %0t: check %0d", $time, checks_done); end end
module tb_top
  import csud_pkg::*;
();
  localparam logic [31:0] PRE = 32'h5A5A_A5A5;
  logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, hung;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, junk;
  logic        sub_overflow, mul_exec, div_exec, carry_flag, error_flag, irq;
  logic        cy, errf, jerr;
  int          errors, checks_done;

  csud_unit DUT (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sub_overflow(sub_overflow), .mul_exec(mul_exec),
    .div_exec(div_exec), .carry_flag(carry_flag), .error_flag(error_flag), .irq(irq));
  csud_seq seq (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .hung(hung));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic give_verdict;
    begin
      $display("errors %0d checks_done %0d", errors, checks_done);
      if (errors == 0 && checks_done > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    seq.xfer(1'b1, a, d, junk, jerr);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    begin
      seq.xfer(1'b0, a, 32'h0000_0000, r, e);
      `CHK(r, x)
      `CHK(e, xe)
    end
  endtask

  function automatic logic [7:0] wa(input int i);
    return 8'h40 + 8'(4 * (i % 16));
  endfunction

  task automatic w32(input int i, input logic [31:0] v);
    wr(wa(i), {16'h0000, v[15:0]});
    wr(wa(i + 1), {16'h0000, v[31:16]});
  endtask

  task automatic r32(input int i, input logic [31:0] v);
    rd(wa(i), {16'h0000, v[15:0]}, 1'b0);
    rd(wa(i + 1), {16'h0000, v[31:16]}, 1'b0);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  // Sources are word pairs 0 and 2, destination pair 4.
  task automatic run(input csud_op_t op, input logic en);
    wr(CSUD_OFF_CMD, {16'h0000, 4'h4, 4'h2, 4'h0, 1'b0, en, op});
    settle(2);
  endtask

  task automatic sub(input logic [31:0] a, input logic [31:0] b, input logic en);
    logic [32:0] d;
    longint      t;
    begin
      w32(0, a);
      w32(2, b);
      w32(4, PRE);
      run(CSUD_OP_SUB, en);
      d = {1'b0, a} - {1'b0, b} - {32'h0000_0000, cy};
      t = longint'($signed(a)) - longint'($signed(b)) - longint'(cy);
      r32(4, en ? d[31:0] : PRE);
      `CHK(sub_overflow, en && (t != longint'($signed(d[31:0]))))
      if (en) cy = d[32];
      `CHK(carry_flag, cy)
    end
  endtask

  task automatic md(input csud_op_t op, input logic [15:0] a, input logic [15:0] b,
                    input logic en);
    logic [31:0] x;
    logic        ok;
    begin
      ok = en && (op == CSUD_OP_MUL || b != 16'h0000);
      x = PRE;
      if (ok) x = (op == CSUD_OP_MUL) ? 32'(a) * 32'(b) : {a % b, a / b};
      w32(0, {16'h0000, a});
      w32(2, {16'h0000, b});
      w32(4, PRE);
      run(op, en);
      r32(4, x);
      if (op == CSUD_OP_MUL) `CHK(mul_exec, ok)
      else `CHK(div_exec, ok)
      if (en && op == CSUD_OP_DIV && b == 16'h0000) errf = 1'b1;
      `CHK(error_flag, errf)
    end
  endtask

  initial
  begin
    #500_000;
    errors++;
    give_verdict;
  end

  initial
  begin
    reset_n = 1'b0;
    errors = 0;
    checks_done = 0;
    cy = 1'b0;
    errf = 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    settle(3);
    `CHK(irq, 1'b0)
    rd(CSUD_OFF_FLAGS, 32'h0000_0000, 1'b0);
    rd(CSUD_OFF_IMASK, 32'h0000_0000, 1'b0);
    rd(CSUD_OFF_CMD, 32'h0000_0000, 1'b0);
    r32(4, 32'h0000_0000);
    sub(32'h135A_4E00, 32'h3D02_6A2D, 1'b1);
    sub(32'h8000_0000, 32'h0000_0001, 1'b1);
    wr(CSUD_OFF_FLAGS, 32'h0000_0001);
    cy = 1'b1;
    sub(32'h0000_0005, 32'h0000_0003, 1'b0);
    sub(32'h7FFF_FFFF, 32'hFFFF_FFFF, 1'b1);
    sub(32'h7FFF_FFFF, 32'hFFFF_FFFE, 1'b1);
    md(CSUD_OP_MUL, 16'hF368, 16'hE822, 1'b1);
    md(CSUD_OP_MUL, 16'hFFFF, 16'hFFFF, 1'b1);
    md(CSUD_OP_MUL, 16'h0003, 16'h0004, 1'b0);
    md(CSUD_OP_DIV, 16'hD431, 16'h007F, 1'b1);
    md(CSUD_OP_DIV, 16'hFFFF, 16'h0003, 1'b1);
    md(CSUD_OP_DIV, 16'h0064, 16'h0000, 1'b1);
    md(CSUD_OP_DIV, 16'h0007, 16'h0002, 1'b1);
    md(CSUD_OP_DIV, 16'h0009, 16'h0003, 1'b0);
    wr(CSUD_OFF_FLAGS, {30'h0, 1'b1, cy});
    errf = 1'b0;
    settle(1);
    `CHK(error_flag, 1'b0)
    wr(CSUD_OFF_IMASK, 32'h0000_0000);
    seq.xfer(1'b0, CSUD_OFF_ISTAT, 32'h0000_0000, junk, jerr);
    md(CSUD_OP_DIV, 16'h0009, 16'h0000, 1'b1);
    `CHK(irq, 1'b0)
    wr(CSUD_OFF_IMASK, 32'h0000_0002);
    settle(2);
    `CHK(irq, 1'b1)
    rd(CSUD_OFF_ISTAT, 32'h0000_0006, 1'b0);
    settle(1);
    `CHK(irq, 1'b0)
    run(CSUD_OP_NONE, 1'b1);
    r32(4, PRE);
    rd(CSUD_OFF_ISTAT, 32'h0000_0004, 1'b0);
    rd(8'h10, 32'h0000_0000, 1'b1);
    `CHK(hung, 1'b0)
    give_verdict;
  end
endmodule
`default_nettype wire
